// File: core/ppm_pkg.sv
`default_nettype none
package ppm_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0]  PPM_OFS_CSR        = 8'ha4;
    localparam logic [7:0]  PPM_OFS_BSE        = 8'ha6;
    localparam logic [15:0] PPM_CSR_RESET      = 16'h0000;
    localparam logic [7:0]  PPM_BSE_VALUE      = 8'hc0;
    // ==========================================================
    // field positions
    localparam int          PPM_BIT_WSTAT      = 15;
    localparam int          PPM_BIT_WEN        = 8;
    localparam int          PPM_PS_LSB         = 0;
    localparam int          PPM_BSE_BPCC       = 7;
    localparam int          PPM_BSE_ACT        = 6;
    localparam int          PPM_NUM_FUNC       = 2;
    // ==========================================================
    // power states
    typedef enum logic [1:0] {
        PPM_D0    = 2'b00,
        PPM_D1    = 2'b01,
        PPM_D2    = 2'b10,
        PPM_D3HOT = 2'b11
    } ppm_pstate_type;
    // ==========================================================
    // configuration access carrier
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [0:0]  func;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ppm_cfg_req_type;
endpackage : ppm_pkg
`default_nettype wire

// File: core/ppm_func_regs.sv
`timescale 1ns/100ps
`default_nettype none
module ppm_func_regs (
    // clock and resets
    input  wire logic                   sys_clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   pci_rst_sync_i,
    // write controls and wake event
    input  wire logic                   wr_lo_i,
    input  wire logic                   wr_hi_i,
    input  wire logic [15:0]            wdata_i,
    input  wire logic                   wake_evt_i,
    // state
    output logic                        wake_status_flag_o,
    output logic                        wake_enable_o,
    output ppm_pkg::ppm_pstate_type     power_state_o,
    output logic                        d3_to_d0_o
);
    import ppm_pkg::*;
    // ==========================================================
    // per-function control/status state
    logic           wstat_r;
    logic           wstat_nxt;
    logic           wen_r;
    logic           wen_nxt;
    ppm_pstate_type ps_r;
    ppm_pstate_type ps_nxt;
    logic           d3d0_r;
    wire            clr_wstat = wr_hi_i & wdata_i[PPM_BIT_WSTAT];   // see [RULE_02] see [RULE_03]
    wire            ps_wr     = wr_lo_i;
    wire ppm_pstate_type ps_new = ppm_pstate_type'(wdata_i[PPM_PS_LSB +: 2]);
    // wake context bits survive bus reset only while enabled
    wire            bus_clr   = pci_rst_sync_i & ~wen_r;            // see [RULE_12]
    assign wstat_nxt = bus_clr ? 1'b0
                     : (wake_evt_i ? 1'b1 : (clr_wstat ? 1'b0 : wstat_r)); // see [RULE_01]
    assign wen_nxt   = wr_hi_i ? wdata_i[PPM_BIT_WEN] : wen_r;     // see [RULE_07]
    // inner d3hot->d0 reset never touches these bits
    assign ps_nxt    = pci_rst_sync_i ? PPM_D0 : (ps_wr ? ps_new : ps_r); // see [RULE_08] see [RULE_10] see [RULE_18]
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wstat_r <= PPM_CSR_RESET[PPM_BIT_WSTAT];
            wen_r   <= PPM_CSR_RESET[PPM_BIT_WEN];
            ps_r    <= PPM_D0;
            d3d0_r  <= 1'b0;
        end else begin
            wstat_r <= wstat_nxt;
            wen_r   <= wen_nxt;
            ps_r    <= ps_nxt;
            d3d0_r  <= ps_wr & (ps_r == PPM_D3HOT) & (ps_new == PPM_D0); // see [RULE_11]
        end
    end
    assign wake_status_flag_o = wstat_r;
    assign wake_enable_o      = wen_r;
    assign power_state_o      = ps_r;
    assign d3_to_d0_o         = d3d0_r;
endmodule : ppm_func_regs
`default_nettype wire

// File: core/ppm_ctrl.sv
// How it works
// [RULE_01] wake event sets status regardless of enable
// [RULE_02] writing one clears status and wake output
// [RULE_03] writing zero leaves status unchanged
// [RULE_04] data scale field reads zero
// [RULE_05] data select field reads zero
// [RULE_06] wake output driven only while enabled
// [RULE_07] enable survives bus reset, cleared globally
// [RULE_08] power state field readable and writable
// [RULE_09] reserved bits read zero
// [RULE_10] internal reset leaves register intact
// [RULE_11] d3hot to d0 resets other function registers
// [RULE_12] wake bits kept on bus reset if enabled
// [RULE_13] each function has own copy
// [RULE_14] bus control enable reads one
// [RULE_15] disabled control leaves secondary bus alone
// [RULE_16] action bit one: d3hot stops secondary clock
// [RULE_17] action bit used only when enable set
// [RULE_18] power state write visible immediately
`timescale 1ns/100ps
`default_nettype none
module ppm_ctrl #(
    parameter int NUM_FUNC = ppm_pkg::PPM_NUM_FUNC
) (
    // clock and resets
    input  wire logic                     sys_clk_i,
    input  wire logic                     global_reset_n_i,
    input  wire logic                     pci_bus_reset_n_i,
    // configuration access
    input  wire ppm_pkg::ppm_cfg_req_type cfg_req_i,
    output logic [31:0]                   cfg_rdata_o,
    output logic                          cfg_rvalid_o,
    // function events
    input  wire logic [NUM_FUNC-1:0]      wake_evt_i,
    // outputs
    output logic                          wake_n_o,
    output logic [NUM_FUNC-1:0]           func_soft_reset_o,
    output logic                          sec_clk_stop_o,
    output logic [2*NUM_FUNC-1:0]         power_state_o
);
    import ppm_pkg::*;
    // ==========================================================
    // bus reset synchroniser
    logic pci_bus_reset_n_meta_r;
    logic pci_bus_reset_n_sync_r;
    always_ff @(posedge sys_clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            pci_bus_reset_n_meta_r <= 1'b0;
            pci_bus_reset_n_sync_r <= 1'b0;
        end else begin
            pci_bus_reset_n_meta_r <= ~pci_bus_reset_n_i;
            pci_bus_reset_n_sync_r <= pci_bus_reset_n_meta_r;
        end
    end
    // ==========================================================
    // wake event synchroniser
    logic [NUM_FUNC-1:0] evt_meta_r;
    logic [NUM_FUNC-1:0] evt_sync_r;
    always_ff @(posedge sys_clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            evt_meta_r <= '0;
            evt_sync_r <= '0;
        end else begin
            evt_meta_r <= wake_evt_i;
            evt_sync_r <= evt_meta_r;
        end
    end
    // ==========================================================
    // decode
    function automatic logic csr_hit(input ppm_cfg_req_type r);
        csr_hit = (r.addr[7:2] == PPM_OFS_CSR[7:2]);
    endfunction : csr_hit
    wire            hit      = csr_hit(cfg_req_i);
    wire            wr_lo    = cfg_req_i.wr & hit & cfg_req_i.be[0];
    wire            wr_hi    = cfg_req_i.wr & hit & cfg_req_i.be[1];
    // ==========================================================
    // function instances
    logic [NUM_FUNC-1:0] wstat;
    logic [NUM_FUNC-1:0] wen;
    logic [NUM_FUNC-1:0] d3d0;
    ppm_pstate_type      ps [NUM_FUNC];
    logic [15:0]         csr_word [NUM_FUNC];
    genvar g;
    generate
        for (g = 0; g < NUM_FUNC; g++) begin : g_func
            wire sel = (cfg_req_i.func == 1'(g));                    // see [RULE_13]
            ppm_func_regs u_regs (
                .sys_clk_i          (sys_clk_i),
                .arst_n_i           (global_reset_n_i),
                .pci_rst_sync_i     (pci_bus_reset_n_sync_r),
                .wr_lo_i            (wr_lo & sel),
                .wr_hi_i            (wr_hi & sel),
                .wdata_i            (cfg_req_i.wdata[15:0]),
                .wake_evt_i         (evt_sync_r[g]),
                .wake_status_flag_o (wstat[g]),
                .wake_enable_o      (wen[g]),
                .power_state_o      (ps[g]),
                .d3_to_d0_o         (d3d0[g])
            );
            // scale, select and reserved bits are tied low
            assign csr_word[g] = {wstat[g], 6'h00, wen[g], 6'h00, ps[g]}; // see [RULE_04] see [RULE_05] see [RULE_09]
        end
    endgenerate
    // ==========================================================
    // read path
    wire [7:0]  bse_byte = PPM_BSE_VALUE;                           // see [RULE_14] see [RULE_16]
    wire [31:0] rd_word  = {8'h00, bse_byte, csr_word[cfg_req_i.func]};
    logic [31:0] rdata_r;
    logic        rvalid_r;
    always_ff @(posedge sys_clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            rdata_r  <= 32'h0000_0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= cfg_req_i.rd;
            rdata_r  <= (cfg_req_i.rd & hit) ? rd_word : 32'h0000_0000;
        end
    end
    // ==========================================================
    // wake output, power state and secondary bus
    wire bpcc_on = bse_byte[PPM_BSE_BPCC];
    wire act_b2  = bse_byte[PPM_BSE_ACT];
    logic [NUM_FUNC-1:0]   d3hot;
    logic [2*NUM_FUNC-1:0] ps_flat;
    always_comb begin
        for (int i = 0; i < NUM_FUNC; i++) begin
            d3hot[i]           = (ps[i] == PPM_D3HOT);
            ps_flat[2*i +: 2]  = ps[i];
        end
    end
    logic                  wake_n_r;
    logic [NUM_FUNC-1:0]   srst_r;
    logic                  sclk_stop_r;
    logic [2*NUM_FUNC-1:0] ps_r;
    always_ff @(posedge sys_clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            wake_n_r    <= 1'b1;
            srst_r      <= '0;
            sclk_stop_r <= 1'b0;
            ps_r        <= '0;
        end else begin
            wake_n_r    <= ~|(wstat & wen);                         // see [RULE_06] see [RULE_02]
            srst_r      <= d3d0;                                    // see [RULE_11]
            sclk_stop_r <= bpcc_on & act_b2 & |d3hot;               // see [RULE_15] see [RULE_16] see [RULE_17]
            ps_r        <= ps_flat;
        end
    end
    assign cfg_rdata_o       = rdata_r;
    assign cfg_rvalid_o      = rvalid_r;
    assign wake_n_o          = wake_n_r;
    assign func_soft_reset_o = srst_r;
    assign sec_clk_stop_o    = sclk_stop_r;
    assign power_state_o     = ps_r;
endmodule : ppm_ctrl
`default_nettype wire

// File: testbench/ppm_host.sv
`timescale 1ns/100ps
`default_nettype none
module ppm_host (
    // clock
    input  wire logic                   sys_clk_i,
    // configuration access
    output var ppm_pkg::ppm_cfg_req_type req_o,
    input  wire logic [31:0]            rdata_i,
    input  wire logic                   rvalid_i
);
    import ppm_pkg::*;
    initial req_o = '0;
    // released lines show inverted pattern, not a held value
    task automatic cfg_wr(input logic f, input logic [3:0] be, input logic [31:0] d);
        @(posedge sys_clk_i);
        #10 req_o = '{rd: 1'b0, wr: 1'b1, func: f, addr: PPM_OFS_CSR, be: be, wdata: d};
        @(posedge sys_clk_i);
        #10 req_o = '{rd: 1'b0, wr: 1'b0, func: ~f, addr: ~PPM_OFS_CSR, be: ~be, wdata: ~d};
    endtask : cfg_wr
    task automatic cfg_rd(input logic f, output logic [31:0] d);
        @(posedge sys_clk_i);
        #10 req_o = '{rd: 1'b1, wr: 1'b0, func: f, addr: PPM_OFS_CSR, be: 4'hf,
                      wdata: ~req_o.wdata};
        @(posedge sys_clk_i);
        #10 req_o = '{rd: 1'b0, wr: 1'b0, func: ~f, addr: ~PPM_OFS_CSR, be: 4'h0,
                      wdata: ~req_o.wdata};
        for (int n = 0; n < 4 && rvalid_i !== 1'b1; n++) @(posedge sys_clk_i) #10;
        d = rdata_i;
    endtask : cfg_rd
endmodule : ppm_host
`default_nettype wire

// File: testbench/ppm_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ppm_ctrl_chk #(
    parameter int NUM_FUNC = 2
) (
    input  wire logic                     sys_clk_i,
    input  wire logic                     global_reset_n_i,
    input  wire logic                     pci_bus_reset_n_i,
    input  wire ppm_pkg::ppm_cfg_req_type cfg_req_i,
    input  wire logic [31:0]              cfg_rdata_o,
    input  wire logic                     cfg_rvalid_o,
    input  wire logic [NUM_FUNC-1:0]      wake_evt_i,
    input  wire logic                     wake_n_o,
    input  wire logic [NUM_FUNC-1:0]      func_soft_reset_o,
    input  wire logic                     sec_clk_stop_o,
    input  wire logic [2*NUM_FUNC-1:0]    power_state_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!global_reset_n_i);
    wire csr_hit = cfg_req_i.addr[7:2] == 6'h29;
    // ==========================================================
    // assertions
    a_rvalid_after_rd: assert property (
        cfg_req_i.rd |=> cfg_rvalid_o
    ) else $error("read not answered next cycle");
    a_no_stray_rvalid: assert property (
        !$past(cfg_req_i.rd) |-> !cfg_rvalid_o
    ) else $error("read valid without read");
    a_reserved_zero: assert property (
        cfg_rvalid_o |-> cfg_rdata_o[31:24] == 8'h00
            && cfg_rdata_o[14:9] == 6'h00 && cfg_rdata_o[7:2] == 6'h00
    ) else $error("reserved bits set");
    a_bse_constant: assert property (
        cfg_rvalid_o && $past(csr_hit) |-> cfg_rdata_o[23:16] == 8'hc0
    ) else $error("extension byte wrong");
    a_clk_stop_d3: assert property (
        sec_clk_stop_o == (power_state_o[1:0] == 2'b11 || power_state_o[3:2] == 2'b11)
    ) else $error("clock stop disagrees with state");
    a_state_write: assert property (
        cfg_req_i.wr && csr_hit && cfg_req_i.be[0] && !cfg_req_i.func
            |-> ##2 power_state_o[1:0] == $past(cfg_req_i.wdata[1:0], 2)
    ) else $error("state write lost");
    a_srst_pulse: assert property (
        func_soft_reset_o[0] |=> !func_soft_reset_o[0]
    ) else $error("soft reset not one cycle");
    a_srst_to_d0: assert property (
        $rose(func_soft_reset_o[0]) |-> ##[0:2] power_state_o[1:0] == 2'b00
    ) else $error("soft reset without move to d0");
    c_read: cover property (cfg_rvalid_o);
    c_wake: cover property ($fell(wake_n_o));
    c_srst: cover property ($rose(func_soft_reset_o[1]));
    c_clk_stop: cover property ($rose(sec_clk_stop_o));
endmodule : ppm_ctrl_chk
`default_nettype wire

// File: testbench/pci_power_mgmt_ctrl_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pci_power_mgmt_ctrl_status_tb;
    import ppm_pkg::*;
    logic clk, gr_n = 1'b0, br_n = 1'b1, wake_n, clk_stop, rvalid;
    logic [1:0] evt = 2'b00, srst, seen = 2'b00;
    logic [3:0] ps;
    logic [31:0] rdata, d;
    ppm_cfg_req_type req;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    ppm_ctrl u_dut (.sys_clk_i(clk), .global_reset_n_i(gr_n), .pci_bus_reset_n_i(br_n),
        .cfg_req_i(req), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .wake_evt_i(evt),
        .wake_n_o(wake_n), .func_soft_reset_o(srst), .sec_clk_stop_o(clk_stop),
        .power_state_o(ps));
    ppm_host u_host (.sys_clk_i(clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        seen <= gr_n ? (seen | srst) : 2'b00;
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            $display("mismatch t=%0t timeout", $time);
            give_verdict();
        end
    end
    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch t=%0t exp %h got %h", $time, e, g);
        end
    endtask : chk
    task automatic rd_chk(input logic f, input logic [31:0] e);
        u_host.cfg_rd(f, d);
        chk(e, d);
    endtask : rd_chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : wt
    task automatic pulse(input logic [1:0] v);
        @(posedge clk) #10 evt = v;
        @(posedge clk) #10 evt = 2'b00;
    endtask : pulse
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    // ==========================================================
    // sequence
    initial begin
        wt(2);
        gr_n = 1'b1;
        rd_chk(1'b0, 32'h00c00000);
        for (int s = 0; s < 4; s++) begin
            u_host.cfg_wr(1'b1, 4'h1, 32'(s));
            rd_chk(1'b1, 32'h00c00000 | 32'(s));
        end
        u_host.cfg_wr(1'b1, 4'h1, 32'h0);
        wt(3);
        chk(2'b10, seen);
        u_host.cfg_wr(1'b0, 4'h3, 32'h00000103);
        wt(2);
        chk(1'b1, clk_stop);
        chk(4'h3, ps);
        rd_chk(1'b1, 32'h00c00000);
        u_host.cfg_wr(1'b0, 4'h4, 32'h00ff0000);
        rd_chk(1'b0, 32'h00c00103);
        u_host.cfg_wr(1'b0, 4'h1, 32'h0);
        rd_chk(1'b0, 32'h00c00100);
        chk(2'b11, seen);
        chk(1'b0, clk_stop);
        pulse(2'b01);
        wt(5);
        chk(1'b0, wake_n);
        rd_chk(1'b0, 32'h00c08100);
        u_host.cfg_wr(1'b0, 4'h2, 32'h00000100);
        rd_chk(1'b0, 32'h00c08100);
        u_host.cfg_wr(1'b0, 4'h2, 32'h00008100);
        wt(2);
        chk(1'b1, wake_n);
        rd_chk(1'b0, 32'h00c00100);
        pulse(2'b10);
        wt(5);
        chk(1'b1, wake_n);
        rd_chk(1'b1, 32'h00c08000);
        u_host.cfg_wr(1'b1, 4'h1, 32'h00000002);
        pulse(2'b01);
        wt(5);
        br_n = 1'b0;
        wt(4);
        br_n = 1'b1;
        wt(3);
        rd_chk(1'b0, 32'h00c08100);
        rd_chk(1'b1, 32'h00c00000);
        gr_n = 1'b0;
        wt(2);
        gr_n = 1'b1;
        rd_chk(1'b0, 32'h00c00000);
        chk(1'b1, wake_n);
        give_verdict();
    end
endmodule : pci_power_mgmt_ctrl_status_tb
bind ppm_ctrl ppm_ctrl_chk #(.NUM_FUNC(NUM_FUNC)) u_chk (.sys_clk_i(sys_clk_i),
    .global_reset_n_i(global_reset_n_i), .pci_bus_reset_n_i(pci_bus_reset_n_i),
    .cfg_req_i(cfg_req_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .wake_evt_i(wake_evt_i), .wake_n_o(wake_n_o), .func_soft_reset_o(func_soft_reset_o),
    .sec_clk_stop_o(sec_clk_stop_o), .power_state_o(power_state_o));
`default_nettype wire
